/* File: design/pcg_clkdiv.sv */
// samples one foreign clock into pclk and divides it by two
`timescale 1ns/1ps
module pcg_clkdiv
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // carrier
  pcg_div_if.div dv
);
  logic meta;
  logic sync;
  logic prev;
  logic half;

  // two flops before any logic; edge detect compares the second one with a third flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      half <= 1'b0;
    end else begin
      meta <= dv.raw_in;
      sync <= meta;
      prev <= sync;
      if (sync && !prev) begin
        half <= ~half; // toggle once per source period
      end
    end
  end

  assign dv.clk_sync = sync;
  assign dv.clk_div2 = half;
endmodule

/* File: design/pcg_top.sv */
// pll clock generator control: registers, clock select, lock flag, stop
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pcg_top
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clocks from the oscillator and vco, foreign to pclk
  input wire logic crystal_clock,
  input wire logic vco_clock,
  // analog loop status pins, foreign to pclk
  input wire logic loop_locked,
  input wire logic loop_tracking,
  // mcu state, same domain
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic break_state,
  // outputs
  output logic crystal_clock_out,
  output logic base_clock_out,
  output logic pll_irq_out,
  output logic pll_enable
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic irq_en;
  logic flag;
  logic pll_on;
  logic base_clock_select;
  logic auto_bw;
  logic acq_manual;
  logic [3:0] mul;
  logic [3:0] vrs;
  logic bce;
  logic lock_prev;
  logic [1:0] lock_sync;
  logic [1:0] trk_sync;

  // ----------------------------------------------------------------
  // clock samplers
  // ----------------------------------------------------------------
  pcg_div_if xdv ();
  pcg_div_if vdv ();
  assign xdv.raw_in = crystal_clock;
  assign vdv.raw_in = vco_clock;
  pcg_clkdiv u_xdiv (.pclk(pclk), .presetn(presetn), .dv(xdv));
  pcg_clkdiv u_vdiv (.pclk(pclk), .presetn(presetn), .dv(vdv));

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_ctrl = paddr[11:4] == 8'h00 && paddr[3:0] == PCG_OFF_CTRL;
  wire hit_bw = paddr[11:4] == 8'h00 && paddr[3:0] == PCG_OFF_BW;
  wire hit_prog = paddr[11:4] == 8'h00 && paddr[3:0] == PCG_OFF_PROG;
  wire hit_bfc = paddr[11:4] == 8'h00 && paddr[3:0] == PCG_OFF_BFC;
  wire mapped = hit_ctrl || hit_bw || hit_prog || hit_bfc;
  wire wr = access_ph && pwrite && mapped;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_bw = wr && hit_bw;
  wire wr_prog = wr && hit_prog;
  wire wr_bfc = wr && hit_bfc;
  wire rd_ctrl = access_ph && !pwrite && hit_ctrl;
  assign pready = 1'b1; // every access completes in its first access cycle
  assign pslverr = access_ph && !mapped;

  // ----------------------------------------------------------------
  // derived control
  // ----------------------------------------------------------------
  wire range_zero = vrs == PCG_VRS_OFF;
  wire pll_active = pll_on && !range_zero;
  wire lock_ind = auto_bw && pll_active && lock_sync[1];
  wire trk_ind = auto_bw && pll_active && trk_sync[1];
  wire lock_evt = auto_bw && (lock_ind != lock_prev);
  wire clr_ok = !break_state || bce;
  wire flag_clr = rd_ctrl && clr_ok;
  wire flag_rd = flag && auto_bw;
  // wait mode deliberately changes nothing here
  wire wait_ignored = wait_mode;
  // interlocks judge the value held before this write
  wire bcs_wr = pwdata[PCG_CTRL_BCS];
  wire pon_wr = pwdata[PCG_CTRL_PLL_ON];
  wire bcs_set_ok = pll_on && !range_zero;
  wire pon_clr_ok = !base_clock_select;
  wire next_bcs = bcs_wr && bcs_set_ok;
  wire next_pll_on = pon_wr || !pon_clr_ok;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_ctrl_val = {irq_en && auto_bw, flag_rd, pll_on, base_clock_select, PCG_CTRL_UNUSED};
  wire acq_rd = auto_bw ? trk_ind : acq_manual;
  wire [7:0] rd_bw_val = {auto_bw, lock_ind, acq_rd, 5'h00};
  wire [7:0] rd_prog_val = {mul, vrs};
  wire [7:0] rd_bfc_val = {bce, 7'h00};
  wire [7:0] rd_val = hit_ctrl ? rd_ctrl_val :
                      hit_bw ? rd_bw_val :
                      hit_prog ? rd_prog_val :
                      hit_bfc ? rd_bfc_val : 8'h00;

  // ----------------------------------------------------------------
  // status pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sync <= 2'b00;
      trk_sync <= 2'b00;
    end else begin
      lock_sync <= {lock_sync[0], loop_locked};
      trk_sync <= {trk_sync[0], loop_tracking};
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in setup so it comes from a flop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 1'b0;
      pll_on <= PCG_RST_PLL_ON;
      base_clock_select <= 1'b0;
    end else begin
      if (wr_ctrl && auto_bw) begin
        irq_en <= pwdata[PCG_CTRL_IRQ_EN];
      end
      if (stop_mode || range_zero) begin
        base_clock_select <= 1'b0;
      end else if (wr_ctrl) begin
        base_clock_select <= next_bcs;
      end
      if (wr_ctrl) begin
        pll_on <= next_pll_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // lock change flag; a new event beats a same-cycle clearing read
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= lock_ind;
      if (lock_evt) begin
        flag <= 1'b1;
      end else if (flag_clr) begin
        flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bandwidth, programming and break registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_bw <= 1'b0;
      acq_manual <= 1'b0;
      mul <= PCG_RST_MUL;
      vrs <= PCG_RST_VRS;
      bce <= 1'b0;
    end else begin
      if (wr_bw) begin
        auto_bw <= pwdata[PCG_BW_AUTO];
      end
      // manual value is kept while auto runs and comes back afterwards
      if (wr_bw && !auto_bw) begin
        acq_manual <= pwdata[PCG_BW_ACQ];
      end
      if (wr_prog && !pll_on) begin
        mul <= pwdata[7:4];
        vrs <= pwdata[3:0];
      end
      if (wr_bfc) begin
        bce <= pwdata[PCG_BFC_BCE];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs; stop forces every clock generator output low
  // ----------------------------------------------------------------
  wire base_src = base_clock_select ? vdv.clk_div2 : xdv.clk_div2;
  wire irq_lvl = flag && irq_en && auto_bw;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_clock_out <= 1'b0;
      base_clock_out <= 1'b0;
      pll_irq_out <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      crystal_clock_out <= xdv.clk_sync && !stop_mode;
      base_clock_out <= base_src && !stop_mode;
      pll_irq_out <= irq_lvl && !stop_mode;
      pll_enable <= pll_active && !stop_mode;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_range_locked: assert property (
    wr_prog && pll_on |=> $stable(vrs))
    else $error("range field changed while pll on");
  chk_range_zero: assert property (
    range_zero |=> !base_clock_select)
    else $error("select set with zero range");
  chk_bcs_refuse: assert property (
    wr_ctrl && bcs_wr && !base_clock_select && (range_zero || !pll_on) |=> !base_clock_select)
    else $error("select accepted against interlock");
  chk_pon_hold: assert property (
    base_clock_select && wr_ctrl && !pon_wr |=> pll_on)
    else $error("pll powered off while selected");
  chk_flag_event: assert property (
    lock_evt |=> flag)
    else $error("lock change not flagged");
  chk_flag_clear: assert property (
    flag_clr && !lock_evt |=> !flag)
    else $error("control read did not clear flag");
  chk_break_keep: assert property (
    break_state && !bce && !lock_evt && flag |=> flag)
    else $error("flag lost during protected break");
  chk_irq_level: assert property (
    flag && irq_en && auto_bw && !stop_mode |=> pll_irq_out)
    else $error("irq missing for set flag");
  chk_no_auto_irq: assert property (
    !auto_bw ##1 !auto_bw |-> !pll_irq_out)
    else $error("irq while auto off");
  chk_stop_low: assert property (
    stop_mode |=> !base_clock_out && !crystal_clock_out && !pll_irq_out)
    else $error("output active in stop");
  chk_stop_bcs: assert property (
    stop_mode |=> !base_clock_select)
    else $error("select kept during stop");
  chk_range_off: assert property (
    range_zero |=> !pll_enable)
    else $error("pll enabled with zero range");
  // wait mode must leave the interrupt path running
  chk_wait_irq: assert property (
    wait_ignored && flag && irq_en && auto_bw && !stop_mode |=> pll_irq_out)
    else $error("irq held back in wait");

  cov_lock_irq: cover property (lock_evt && irq_en ##1 pll_irq_out);
  cov_vco_sel: cover property (wr_ctrl && bcs_wr ##1 base_clock_select);
  cov_break_rd: cover property (rd_ctrl && break_state && flag);
  cov_stop_vco: cover property (base_clock_select ##1 stop_mode);
  cov_wait_lock: cover property (wait_ignored && lock_evt);
endmodule

/* File: inc/pcg_div_if.sv */
// carrier between the control top and one clock sampler/divider
`timescale 1ns/1ps
interface pcg_div_if;
  logic raw_in;
  logic clk_sync;
  logic clk_div2;
  modport div (input raw_in, output clk_sync, output clk_div2);
  modport user (output raw_in, input clk_sync, input clk_div2);
endinterface

/* File: inc/pcg_pkg.sv */
// constants for the pll clock generator control block
package pcg_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] PCG_OFF_CTRL = 4'h0; // pll_control_reg
  localparam logic [3:0] PCG_OFF_BW = 4'h4; // pll_bandwidth_reg
  localparam logic [3:0] PCG_OFF_PROG = 4'h8; // pll_programming_reg
  localparam logic [3:0] PCG_OFF_BFC = 4'hc; // break_flag_control_reg
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCG_CTRL_IRQ_EN = 7;
  localparam int PCG_CTRL_FLAG = 6;
  localparam int PCG_CTRL_PLL_ON = 5;
  localparam int PCG_CTRL_BCS = 4;
  localparam int PCG_BW_AUTO = 7;
  localparam int PCG_BW_LOCK = 6;
  localparam int PCG_BW_ACQ = 5;
  localparam int PCG_BFC_BCE = 7;
  // ----------------------------------------------------------------
  // reset values and fixed read values
  // ----------------------------------------------------------------
  localparam logic [3:0] PCG_RST_MUL = 4'h6;
  localparam logic [3:0] PCG_RST_VRS = 4'h6;
  localparam logic PCG_RST_PLL_ON = 1'b1;
  localparam logic [3:0] PCG_CTRL_UNUSED = 4'hf; // low control bits read as ones
  localparam logic [3:0] PCG_VRS_OFF = 4'h0;
endpackage

/* File: verif/tb_top.sv */
// self-checking bench for the pll clock generator control block
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e; logic en;} pcg_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, crystal_clock_out, base_clock_out, pll_irq_out, pll_enable;
  logic crystal_clock = 0, vco_clock = 0, loop_locked = 0, loop_tracking = 0;
  logic stop_mode = 0, wait_mode = 0, break_state = 0;
  logic [7:0] rv;
  logic ev, hi;
  int fails = 0, num_checks = 0, rises = 0, xrises = 0;
  // write row then read back: address, data, read value, slverr, pll_enable
  pcg_row_t rows[20] = '{
    '{12'h00c, 8'h80, 8'h80, 1'b0, 1'b1}, '{12'h00c, 8'h00, 8'h00, 1'b0, 1'b1},
    '{12'h008, 8'h35, 8'h66, 1'b0, 1'b1}, '{12'h000, 8'h0f, 8'h0f, 1'b0, 1'b0},
    '{12'h008, 8'h35, 8'h35, 1'b0, 1'b0}, '{12'h000, 8'h1f, 8'h0f, 1'b0, 1'b0},
    '{12'h000, 8'h2f, 8'h2f, 1'b0, 1'b1}, '{12'h000, 8'h3f, 8'h3f, 1'b0, 1'b1},
    '{12'h000, 8'h1f, 8'h3f, 1'b0, 1'b1}, '{12'h000, 8'h8f, 8'h2f, 1'b0, 1'b1},
    '{12'h004, 8'h20, 8'h20, 1'b0, 1'b1}, '{12'h004, 8'h00, 8'h00, 1'b0, 1'b1},
    '{12'h010, 8'hff, 8'h00, 1'b1, 1'b1}, '{12'h000, 8'h0f, 8'h0f, 1'b0, 1'b0},
    '{12'h008, 8'h30, 8'h30, 1'b0, 1'b0}, '{12'h000, 8'h2f, 8'h2f, 1'b0, 1'b0},
    '{12'h000, 8'h3f, 8'h2f, 1'b0, 1'b0}, '{12'h000, 8'h0f, 8'h0f, 1'b0, 1'b0},
    '{12'h008, 8'h36, 8'h36, 1'b0, 1'b0}, '{12'h000, 8'h2f, 8'h2f, 1'b0, 1'b1}};
  logic [7:0] rst_x[4] = '{8'h2f, 8'h00, 8'h66, 8'h00};

  // ------------------------------------------------------------
  // clocks and design
  // ------------------------------------------------------------
  always #5 pclk = ~pclk;
  // foreign clocks kept well below pclk/4 so the synchronisers can follow
  always #100 crystal_clock = ~crystal_clock;
  always #60 vco_clock = ~vco_clock;
  always @(posedge base_clock_out) rises++;
  always @(posedge crystal_clock_out) xrises++;

  pcg_top pcg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
    .loop_locked(loop_locked), .loop_tracking(loop_tracking), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .break_state(break_state), .crystal_clock_out(crystal_clock_out),
    .base_clock_out(base_clock_out), .pll_irq_out(pll_irq_out), .pll_enable(pll_enable));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task stop_test;
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  // one apb transfer; entered right after a rising edge, leaves one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
           output logic [7:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count is assumed; only the watchdog ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_irq(input logic v);
    int k;
    k = 0;
    while (pll_irq_out !== v && k < 20) begin
      k++;
      @(posedge pclk);
    end
  endtask

  // rising edges of the base clock in a fixed window tell which source drives it
  task rate(input int lo, input int hi_n);
    repeat (10) @(posedge pclk);
    rises = 0;
    xrises = 0;
    #4800;
    chk1("base rate", 1'b1, rises >= lo && rises <= hi_n);
    chk1("xtal rate", 1'b1, xrises >= 23 && xrises <= 25);
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rv, ev);
      apb(1'b0, rows[i].a, 8'h00, rv, ev);
      chk8("row read", rows[i].x, rv);
      chk1("row slverr", rows[i].e, ev);
      repeat (2) @(posedge pclk);
      chk1("row pll_enable", rows[i].en, pll_enable);
    end
    // second reset in mid-run, then reset values of every register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(4 * k), 8'h00, rv, ev);
      chk8("reset value", rst_x[k], rv);
    end
    rate(11, 13);
    apb(1'b1, 12'h000, 8'h3f, rv, ev);
    rate(19, 21);
    // stop with the vco driving the base clock
    stop_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    hi = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      hi = hi | crystal_clock_out | base_clock_out | pll_irq_out;
    end
    chk1("stop outputs", 1'b0, hi);
    stop_mode <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("ctrl after stop", 8'h2f, rv);
    rate(11, 13);
    // software drops the vco, then powers the pll down before wait
    apb(1'b1, 12'h000, 8'h3f, rv, ev);
    apb(1'b1, 12'h000, 8'h2f, rv, ev);
    apb(1'b1, 12'h000, 8'h0f, rv, ev);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("ctrl before wait", 8'h0f, rv);
    chk1("pll off before wait", 1'b0, pll_enable);
    // lock entry in wait mode with the interrupt enabled
    wait_mode <= 1'b1;
    apb(1'b1, 12'h004, 8'h80, rv, ev);
    apb(1'b1, 12'h000, 8'haf, rv, ev);
    loop_locked <= 1'b1;
    wait_irq(1'b1);
    chk1("irq on lock", 1'b1, pll_irq_out);
    apb(1'b0, 12'h004, 8'h00, rv, ev);
    chk8("bw locked", 8'hc0, rv);
    loop_tracking <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h004, 8'h00, rv, ev);
    chk8("bw tracking", 8'he0, rv);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("ctrl flag", 8'hef, rv);
    wait_irq(1'b0);
    chk1("irq after read", 1'b0, pll_irq_out);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("ctrl cleared", 8'haf, rv);
    wait_mode <= 1'b0;
    // lock exit with the interrupt disabled
    apb(1'b1, 12'h000, 8'h2f, rv, ev);
    loop_locked <= 1'b0;
    repeat (10) @(posedge pclk);
    chk1("irq masked", 1'b0, pll_irq_out);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("flag unmasked", 8'h6f, rv);
    // debug break: flag kept until clearing is enabled, then stays clear
    break_state <= 1'b1;
    loop_locked <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, 12'h000, 8'h2f, rv, ev);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("break kept", 8'h6f, rv);
    apb(1'b1, 12'h00c, 8'h80, rv, ev);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("break cleared", 8'h2f, rv);
    break_state <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("clear persists", 8'h2f, rv);
    // auto mode switched off with an interrupt pending
    apb(1'b1, 12'h000, 8'haf, rv, ev);
    loop_locked <= 1'b0;
    wait_irq(1'b1);
    chk1("irq on unlock", 1'b1, pll_irq_out);
    apb(1'b1, 12'h004, 8'h00, rv, ev);
    repeat (4) @(posedge pclk);
    chk1("irq auto off", 1'b0, pll_irq_out);
    apb(1'b0, 12'h000, 8'h00, rv, ev);
    chk8("flag auto off", 8'h2f, rv);
    stop_test;
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #100000;
    fails++;
    stop_test;
  end
endmodule
